// ===== cpu_register_file_and_flags.sv
/*
  CPU register file with two banks, pointers, bases and flag register.
  Assumes one clock; decoder and alu drive strobes for one cycle; a
  plain software port reads and writes by selector code.
*/
// Behaviour
// - Two banks of seven registers each
// - Bank flag picks bank zero or one
// - Four 16-bit data registers
// - First two data registers split into bytes
// - Third plus first data form 32 bits
// - Two 16-bit address registers
// - Address pair forms 32-bit operand
// - Frame base is 16 bits
// - Vector table base is 20 bits
// - Instruction pointer is 20 bits
// - Separate user and interrupt stack pointers
// - Stack flag picks interrupt or user pointer
// - Hardware acceptance or software interrupt number up to 1f clears stack flag
// - Static base is 16 bits
// - Eleven-bit status flag register
// - Carry captures carry, borrow, shift-out
// - Zero flag marks zero result
// - Sign flag marks negative result
// - Overflow flag marks overflow
// - Interrupt enable gates maskable, cleared on accept
// - Three-bit priority level, strictly greater accepted
`include "cpu_regs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_register_file_and_flags
  import cpu_regs_pkg::*;
(
  // clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RESET,
  // decoder write port
  input  wire cpu_regs_pkg::reg_write_t   DEC_WR,
  // decoder read selectors
  input  wire cpu_regs_pkg::sel_t         DEC_RD_SEL_A,
  input  wire cpu_regs_pkg::sel_t         DEC_RD_SEL_B,
  // alu flag update
  input  wire logic                       ALU_FLAGS_WE,
  input  wire cpu_regs_pkg::alu_flags_t   ALU_FLAGS,
  // instruction pointer advance
  input  wire logic                       IPTR_LOAD,
  input  wire cpu_regs_pkg::addr20_t      IPTR_NEXT,
  // interrupt handling
  input  wire cpu_regs_pkg::irq_event_t   IRQ_EVT,
  input  wire logic                       IRQ_REQ,
  input  wire logic [2:0]                 IRQ_REQ_LEVEL,
  input  wire logic                       IRQ_REQ_MASKABLE,
  // software port
  input  wire cpu_regs_pkg::sel_t         SW_ADDR,
  input  wire logic [`ADDR20_W-1:0]       SW_WDATA,
  input  wire logic                       SW_WR,
  input  wire logic                       SW_RD,
  output logic [`ADDR20_W-1:0]            SW_RDATA,
  // operand outputs
  output logic [`ADDR20_W-1:0]            RD_DATA_A,
  output logic [`ADDR20_W-1:0]            RD_DATA_B,
  output logic [2*`WORD_W-1:0]            WIDE_DATA_PAIR,
  output logic [2*`WORD_W-1:0]            WIDE_ADDRESS_PAIR,
  output cpu_regs_pkg::word_t             STACK_POINTER,
  output cpu_regs_pkg::addr20_t           VECTOR_TABLE_BASE,
  output cpu_regs_pkg::addr20_t           INSTRUCTION_POINTER,
  output logic [`FLAG_W-1:0]              STATUS_FLAGS,
  output logic                            IRQ_ACCEPT_OK
);
  import cpu_regs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  addr20_t              vector_table_base_ff;
  addr20_t              instruction_pointer_ff;
  word_t                user_stack_pointer_ff;
  word_t                interrupt_stack_pointer_ff;
  word_t                static_base_ff;
  logic [`FLAG_W-1:0]   status_flags_ff;
  logic [`FLAG_W-1:0]   nxt_status_flags;
  logic [7*`WORD_W-1:0] bank0_flat;
  logic [7*`WORD_W-1:0] bank1_flat;
  logic                 wr_en;
  sel_t                 wr_sel;
  addr20_t              wr_data;

  // software write takes precedence over decoder write in one cycle
  assign wr_en   = SW_WR | DEC_WR.en;
  assign wr_sel  = SW_WR ? SW_ADDR : DEC_WR.sel;
  assign wr_data = SW_WR ? SW_WDATA : DEC_WR.data;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic word_t bank_word(input logic [7*`WORD_W-1:0] flat,
                                      input int idx);
    bank_word = flat[idx*`WORD_W +: `WORD_W];
  endfunction

  function automatic logic is_stack_sel(input sel_t s);
    is_stack_sel = (s == `SEL_SP);
  endfunction

  // ----------------------------------------------------------------
  // banks
  // ----------------------------------------------------------------
  logic bank_sel;
  assign bank_sel = status_flags_ff[`FLG_BANK];

  cpu_reg_bank u_bank0 (
    .clk       (REF_CLK),
    .rst       (RESET),
    .wr_en     (wr_en && !bank_sel),
    .wr_sel    (wr_sel),
    .wr_data   (wr_data[`WORD_W-1:0]),
    .regs_flat (bank0_flat)
  );

  cpu_reg_bank u_bank1 (
    .clk       (REF_CLK),
    .rst       (RESET),
    .wr_en     (wr_en && bank_sel),
    .wr_sel    (wr_sel),
    .wr_data   (wr_data[`WORD_W-1:0]),
    .regs_flat (bank1_flat)
  );

  logic [7*`WORD_W-1:0] active_bank;
  assign active_bank = bank_sel ? bank1_flat : bank0_flat;

  // ----------------------------------------------------------------
  // read mux, used by three ports
  // ----------------------------------------------------------------
  function automatic addr20_t read_reg(input sel_t s,
                                       input logic [7*`WORD_W-1:0] bk,
                                       input logic [`FLAG_W-1:0] status_flags,
                                       input addr20_t vtb,
                                       input addr20_t ipt,
                                       input word_t user_stack_pointer,
                                       input word_t interrupt_stack_pointer,
                                       input word_t sb);
    word_t w;
    w = `RST_WORD;
    read_reg = `RST_ADDR20;
    case (s)
      `SEL_DATA0, `SEL_DATA1, `SEL_DATA2, `SEL_DATA3,
      `SEL_ADDR0, `SEL_ADDR1, `SEL_FRAME:
      begin
        w = bank_word(bk, int'(s));
        read_reg = {4'h0, w};
      end
      // byte selectors read zero-extended
      `SEL_D0_LO:
      begin
        w = bank_word(bk, 0);
        read_reg = {12'h000, w[7:0]};
      end
      `SEL_D0_HI:
      begin
        w = bank_word(bk, 0);
        read_reg = {12'h000, w[15:8]};
      end
      `SEL_D1_LO:
      begin
        w = bank_word(bk, 1);
        read_reg = {12'h000, w[7:0]};
      end
      `SEL_D1_HI:
      begin
        w = bank_word(bk, 1);
        read_reg = {12'h000, w[15:8]};
      end
      `SEL_VTAB:  read_reg = vtb;
      `SEL_IPTR:  read_reg = ipt;
      `SEL_USP:   read_reg = {4'h0, user_stack_pointer};
      `SEL_ISP:   read_reg = {4'h0, interrupt_stack_pointer};
      `SEL_SP:    read_reg = {4'h0, status_flags[`FLG_STACK] ? user_stack_pointer : interrupt_stack_pointer};
      `SEL_SBASE: read_reg = {4'h0, sb};
      `SEL_FLAGS: read_reg = {9'h000, status_flags};
      default:    read_reg = `RST_ADDR20;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // vector table base, instruction pointer, static base
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      vector_table_base_ff <= `RST_ADDR20;
    else if (wr_en && wr_sel == `SEL_VTAB)
      vector_table_base_ff <= wr_data;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      instruction_pointer_ff <= `RST_ADDR20;
    else if (wr_en && wr_sel == `SEL_IPTR)
      instruction_pointer_ff <= wr_data;
    else if (IPTR_LOAD)
      instruction_pointer_ff <= IPTR_NEXT;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      static_base_ff <= `RST_WORD;
    else if (wr_en && wr_sel == `SEL_SBASE)
      static_base_ff <= wr_data[`WORD_W-1:0];
  end

  // ----------------------------------------------------------------
  // stack pointers
  // ----------------------------------------------------------------
  // the alias follows the flag as it stands before this edge
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      user_stack_pointer_ff <= `RST_WORD;
    else if (wr_en && (wr_sel == `SEL_USP ||
             (is_stack_sel(wr_sel) && status_flags_ff[`FLG_STACK])))
      user_stack_pointer_ff <= wr_data[`WORD_W-1:0];
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      interrupt_stack_pointer_ff <= `RST_WORD;
    else if (wr_en && (wr_sel == `SEL_ISP ||
             (is_stack_sel(wr_sel) && !status_flags_ff[`FLG_STACK])))
      interrupt_stack_pointer_ff <= wr_data[`WORD_W-1:0];
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic accept_any;
  logic swi_low;
  assign swi_low    = IRQ_EVT.sw_exec && (IRQ_EVT.sw_num <= `SWI_LAST);
  assign accept_any = IRQ_EVT.hw_accept || IRQ_EVT.sw_exec;

  always_comb
  begin
    nxt_status_flags = status_flags_ff;
    if (wr_en && wr_sel == `SEL_FLAGS)
      // debug bit never stored, so it reads zero
      nxt_status_flags = wr_data[`FLAG_W-1:0] & `FLG_WRITE_MASK;
    if (ALU_FLAGS_WE)
    begin
      nxt_status_flags[`FLG_CARRY] = ALU_FLAGS.carry;
      nxt_status_flags[`FLG_ZERO]  = ALU_FLAGS.zero;
      nxt_status_flags[`FLG_SIGN]  = ALU_FLAGS.sign;
      nxt_status_flags[`FLG_OVFL]  = ALU_FLAGS.ovfl;
    end
    // acceptance wins over a same-cycle software write
    if (accept_any)
    begin
      nxt_status_flags[`FLG_IEN] = 1'b0;
      nxt_status_flags[`FLG_IPL_HI:`FLG_IPL_LO] = IRQ_EVT.new_ipl;
    end
    if (IRQ_EVT.hw_accept || swi_low)
      nxt_status_flags[`FLG_STACK] = 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
      status_flags_ff <= `RST_FLAGS;
    else
      status_flags_ff <= nxt_status_flags;
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic [`FLAG_W-1:0] nf;
  assign nf = nxt_status_flags;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      IRQ_ACCEPT_OK <= 1'b0;
      STATUS_FLAGS  <= `RST_FLAGS;
    end
    else
    begin
      // maskable needs enable; every request needs level strictly above
      IRQ_ACCEPT_OK <= IRQ_REQ &&
                       (!IRQ_REQ_MASKABLE || nf[`FLG_IEN]) &&
                       (IRQ_REQ_LEVEL > nf[`FLG_IPL_HI:`FLG_IPL_LO]);
      STATUS_FLAGS  <= nf;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      SW_RDATA            <= `RST_ADDR20;
      RD_DATA_A           <= `RST_ADDR20;
      RD_DATA_B           <= `RST_ADDR20;
      WIDE_DATA_PAIR      <= {`RST_WORD, `RST_WORD};
      WIDE_ADDRESS_PAIR   <= {`RST_WORD, `RST_WORD};
      STACK_POINTER       <= `RST_WORD;
      VECTOR_TABLE_BASE   <= `RST_ADDR20;
      INSTRUCTION_POINTER <= `RST_ADDR20;
    end
    else
    begin
      SW_RDATA <= SW_RD ? read_reg(SW_ADDR, active_bank, status_flags_ff,
                                   vector_table_base_ff, instruction_pointer_ff,
                                   user_stack_pointer_ff,
                                   interrupt_stack_pointer_ff,
                                   static_base_ff) : `RST_ADDR20;
      RD_DATA_A <= read_reg(DEC_RD_SEL_A, active_bank, status_flags_ff,
                            vector_table_base_ff, instruction_pointer_ff,
                            user_stack_pointer_ff, interrupt_stack_pointer_ff,
                            static_base_ff);
      RD_DATA_B <= read_reg(DEC_RD_SEL_B, active_bank, status_flags_ff,
                            vector_table_base_ff, instruction_pointer_ff,
                            user_stack_pointer_ff, interrupt_stack_pointer_ff,
                            static_base_ff);
      // third data register is the upper half
      WIDE_DATA_PAIR    <= {bank_word(active_bank, 2),
                            bank_word(active_bank, 0)};
      // second address register is the upper half
      WIDE_ADDRESS_PAIR <= {bank_word(active_bank, 5),
                            bank_word(active_bank, 4)};
      STACK_POINTER     <= status_flags_ff[`FLG_STACK] ?
                           user_stack_pointer_ff :
                           interrupt_stack_pointer_ff;
      VECTOR_TABLE_BASE   <= vector_table_base_ff;
      INSTRUCTION_POINTER <= instruction_pointer_ff;
    end
  end

endmodule // cpu_register_file_and_flags

`default_nettype wire

// ===== cpu_regs_params.svh
/*
  Constants for the CPU register file: flag bit positions, register
  selector codes, software port offsets, widths and reset values.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef CPU_REGS_PARAMS_SVH
`define CPU_REGS_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define WORD_W        16
`define ADDR20_W      20
`define FLAG_W        11
`define SEL_W         5

// ----------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------
`define FLG_CARRY     0
`define FLG_DEBUG     1
`define FLG_ZERO      2
`define FLG_SIGN      3
`define FLG_BANK      4
`define FLG_OVFL      5
`define FLG_IEN       6
`define FLG_STACK     7
`define FLG_IPL_LO    8
`define FLG_IPL_HI    10
`define FLG_WRITE_MASK 11'h7fd

// ----------------------------------------------------------------
// register selector codes (decoder ports and software offsets)
// ----------------------------------------------------------------
`define SEL_DATA0     5'h00
`define SEL_DATA1     5'h01
`define SEL_DATA2     5'h02
`define SEL_DATA3     5'h03
`define SEL_ADDR0     5'h04
`define SEL_ADDR1     5'h05
`define SEL_FRAME     5'h06
`define SEL_VTAB      5'h07
`define SEL_IPTR      5'h08
`define SEL_USP       5'h09
`define SEL_ISP       5'h0a
`define SEL_SBASE     5'h0b
`define SEL_FLAGS     5'h0c
`define SEL_SP        5'h0d
`define SEL_D0_LO     5'h10
`define SEL_D0_HI     5'h11
`define SEL_D1_LO     5'h12
`define SEL_D1_HI     5'h13

// ----------------------------------------------------------------
// reset values and interrupt numbers
// ----------------------------------------------------------------
`define RST_WORD      16'h0000
`define RST_ADDR20    20'h00000
`define RST_FLAGS     11'h000
`define SWI_LAST      6'h1f

`endif

// ===== cpu_regs_pkg.sv
/*
  Types shared by the register file and its bank submodule.
  Assumes cpu_regs_params.svh is on the include path.
*/
`include "cpu_regs_params.svh"

package cpu_regs_pkg;

  typedef logic [`WORD_W-1:0]   word_t;
  typedef logic [`ADDR20_W-1:0] addr20_t;
  typedef logic [`SEL_W-1:0]    sel_t;

  // result flags from the alu
  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic ovfl;
  } alu_flags_t;

  // one write request into the register file
  typedef struct packed {
    logic    en;
    sel_t    sel;
    addr20_t data;
  } reg_write_t;

  // interrupt acceptance event
  typedef struct packed {
    logic       hw_accept;
    logic       sw_exec;
    logic [5:0] sw_num;
    logic [2:0] new_ipl;
  } irq_event_t;

  // one-hot bank state encoding; cpu_reg_bank has no state machine
  typedef enum logic [1:0] {
    BANK_IDLE  = 2'b01,
    BANK_WRITE = 2'b10
  } bank_state_t;

endpackage : cpu_regs_pkg

// ===== cpu_reg_bank.sv
/*
  One register bank: four data registers, two address registers and
  a frame base. Byte lanes of the first two data registers are
  writable alone. Assumes the parent gates the write enable by bank.
*/
`include "cpu_regs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_reg_bank
  import cpu_regs_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // write port
  input  wire logic                 wr_en,
  input  wire cpu_regs_pkg::sel_t   wr_sel,
  input  wire cpu_regs_pkg::word_t  wr_data,
  // contents
  output logic [7*`WORD_W-1:0]      regs_flat
);
  import cpu_regs_pkg::*;

  word_t regs_ff [7];

  // ----------------------------------------------------------------
  // per-register write
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_reg
      always_ff @(posedge clk)
      begin
        if (rst)
          regs_ff[gi] <= `RST_WORD;
        else if (wr_en && wr_sel == sel_t'(gi))
          regs_ff[gi] <= wr_data;
        else if (wr_en && gi < 2 && wr_sel == sel_t'(`SEL_D0_LO + 2 * gi))
          regs_ff[gi][7:0] <= wr_data[7:0];
        else if (wr_en && gi < 2 && wr_sel == sel_t'(`SEL_D0_HI + 2 * gi))
          regs_ff[gi][15:8] <= wr_data[7:0];
      end
      assign regs_flat[gi*`WORD_W +: `WORD_W] = regs_ff[gi];
    end
  endgenerate

endmodule // cpu_reg_bank

`default_nettype wire

// ===== cpu_regs_props.sv
/*
  Concurrent checks on the register file flag and read ports.
  Assumes binding to cpu_register_file_and_flags, one clock domain.
*/
`include "cpu_regs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_regs_props
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic                     REF_CLK,
  input wire logic                     RESET,
  // stimulus
  input wire cpu_regs_pkg::reg_write_t DEC_WR,
  input wire logic                     ALU_FLAGS_WE,
  input wire cpu_regs_pkg::alu_flags_t ALU_FLAGS,
  input wire cpu_regs_pkg::irq_event_t IRQ_EVT,
  input wire logic                     IRQ_REQ,
  input wire logic [2:0]               IRQ_REQ_LEVEL,
  input wire logic                     IRQ_REQ_MASKABLE,
  input wire cpu_regs_pkg::sel_t       SW_ADDR,
  input wire logic [`ADDR20_W-1:0]     SW_WDATA,
  input wire logic                     SW_WR,
  input wire logic                     SW_RD,
  // results
  input wire logic [`ADDR20_W-1:0]     SW_RDATA,
  input wire logic [`FLAG_W-1:0]       STATUS_FLAGS,
  input wire logic                     IRQ_ACCEPT_OK
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // decoder flag writes have no documented priority, so excluded
  wire logic quiet = !SW_WR && !DEC_WR.en;

  property p_flag_rd;
    SW_RD && SW_ADDR == `SEL_FLAGS |=> SW_RDATA == {9'h0, $past(STATUS_FLAGS)};
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag read mismatch");
  property p_flag_wr;
    SW_WR && SW_ADDR == `SEL_FLAGS && !ALU_FLAGS_WE && !IRQ_EVT.hw_accept && !IRQ_EVT.sw_exec
      |=> STATUS_FLAGS == ($past(SW_WDATA[10:0]) & `FLG_WRITE_MASK);
  endproperty
  a_flag_wr: assert property (p_flag_wr) else $error("flag write mismatch");
  property p_alu_cz;
    quiet && ALU_FLAGS_WE |=> STATUS_FLAGS[0] == $past(ALU_FLAGS.carry)
      && STATUS_FLAGS[2] == $past(ALU_FLAGS.zero);
  endproperty
  a_alu_cz: assert property (p_alu_cz) else $error("carry or zero not loaded");
  property p_alu_so;
    quiet && ALU_FLAGS_WE |=> STATUS_FLAGS[3] == $past(ALU_FLAGS.sign)
      && STATUS_FLAGS[5] == $past(ALU_FLAGS.ovfl);
  endproperty
  a_alu_so: assert property (p_alu_so) else $error("sign or overflow not loaded");
  property p_hw_acc;
    quiet && IRQ_EVT.hw_accept |=> !STATUS_FLAGS[6] && !STATUS_FLAGS[7];
  endproperty
  a_hw_acc: assert property (p_hw_acc) else $error("accept left enable or stack flag");
  property p_ipl_ld;
    quiet && IRQ_EVT.hw_accept |=> STATUS_FLAGS[10:8] == $past(IRQ_EVT.new_ipl);
  endproperty
  a_ipl_ld: assert property (p_ipl_ld) else $error("priority level not loaded");
  property p_swi_lo;
    quiet && IRQ_EVT.sw_exec && IRQ_EVT.sw_num <= 6'h1f |=> !STATUS_FLAGS[7];
  endproperty
  a_swi_lo: assert property (p_swi_lo) else $error("low soft interrupt kept stack flag");
  property p_swi_hi;
    quiet && IRQ_EVT.sw_exec && !IRQ_EVT.hw_accept && IRQ_EVT.sw_num > 6'h1f
      |=> STATUS_FLAGS[7] == $past(STATUS_FLAGS[7]);
  endproperty
  a_swi_hi: assert property (p_swi_hi) else $error("high soft interrupt moved stack flag");
  property p_acc_ok;
    1'b1 |=> IRQ_ACCEPT_OK == ($past(IRQ_REQ) && (!$past(IRQ_REQ_MASKABLE) || STATUS_FLAGS[6])
      && $past(IRQ_REQ_LEVEL) > STATUS_FLAGS[10:8]);
  endproperty
  a_acc_ok: assert property (p_acc_ok) else $error("accept decision wrong");
  property p_hold;
    quiet && !ALU_FLAGS_WE && !IRQ_EVT.hw_accept && !IRQ_EVT.sw_exec |=> $stable(STATUS_FLAGS);
  endproperty
  a_hold: assert property (p_hold) else $error("flags changed without cause");
endmodule // cpu_regs_props

bind cpu_register_file_and_flags cpu_regs_props i_cpu_regs_props (.REF_CLK, .RESET, .DEC_WR,
  .ALU_FLAGS_WE, .ALU_FLAGS, .IRQ_EVT, .IRQ_REQ, .IRQ_REQ_LEVEL, .IRQ_REQ_MASKABLE, .SW_ADDR,
  .SW_WDATA, .SW_WR, .SW_RD, .SW_RDATA, .STATUS_FLAGS, .IRQ_ACCEPT_OK);

`default_nettype wire

// ===== cpu_core_model.sv
/*
  Behavioural decoder and alu that pulse the register file strobes.
  Assumes its tasks are called one at a time from the testbench.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model
  import cpu_regs_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // decoder and alu side
  output var cpu_regs_pkg::reg_write_t dec_wr,
  output var cpu_regs_pkg::sel_t       sel_a,
  output var cpu_regs_pkg::sel_t       sel_b,
  output var logic                     flags_we,
  output var cpu_regs_pkg::alu_flags_t flags,
  output var logic                     ip_load,
  output var cpu_regs_pkg::addr20_t    ip_next,
  output var cpu_regs_pkg::irq_event_t evt
);
  initial
  begin
    dec_wr = '0;
    sel_a = '0;
    sel_b = '0;
    flags_we = 1'b0;
    flags = '0;
    ip_load = 1'b0;
    ip_next = '0;
    evt = '0;
  end
  // released qualifiers show inverted data, never the last value; irq returns the event to zero
  task automatic wr(input sel_t s, input addr20_t d);
    @(posedge clk);
    dec_wr <= '{1'b1, s, d};
    @(posedge clk);
    dec_wr <= '{1'b0, ~s, ~d};
  endtask
  task automatic pick(input sel_t a, input sel_t b);
    @(posedge clk);
    sel_a <= a;
    sel_b <= b;
  endtask
  task automatic alu(input alu_flags_t f);
    @(posedge clk);
    flags_we <= 1'b1;
    flags <= f;
    @(posedge clk);
    flags_we <= 1'b0;
    flags <= ~f;
  endtask
  task automatic jump(input addr20_t a);
    @(posedge clk);
    ip_load <= 1'b1;
    ip_next <= a;
    @(posedge clk);
    ip_load <= 1'b0;
    ip_next <= ~a;
  endtask
  task automatic irq(input irq_event_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask
endmodule // cpu_core_model

`default_nettype wire

// ===== testbench.sv
/*
  Self-checking testbench for the CPU register file.
  Assumes the checker is bound to the design and the core model drives decoder ports.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import cpu_regs_pkg::*;
  logic ref_clk, reset, flags_we, ip_load, irq_req, irq_msk, sw_wr, sw_rd, acc_ok;
  reg_write_t dec_wr;
  sel_t sel_a, sel_b, sw_addr;
  alu_flags_t alu_flags;
  irq_event_t irq_evt;
  logic [2:0] irq_lvl;
  logic [10:0] status_flags;
  logic [31:0] wide_d, wide_a;
  word_t sp;
  addr20_t ip_next, sw_wdata, sw_rdata, rd_a, rd_b, vtb, iptr;
  int error_cnt, checks_done;

  cpu_register_file_and_flags i_cpu_register_file_and_flags (.REF_CLK(ref_clk), .RESET(reset),
    .DEC_WR(dec_wr), .DEC_RD_SEL_A(sel_a), .DEC_RD_SEL_B(sel_b), .ALU_FLAGS_WE(flags_we),
    .ALU_FLAGS(alu_flags), .IPTR_LOAD(ip_load), .IPTR_NEXT(ip_next), .IRQ_EVT(irq_evt),
    .IRQ_REQ(irq_req), .IRQ_REQ_LEVEL(irq_lvl), .IRQ_REQ_MASKABLE(irq_msk), .SW_ADDR(sw_addr),
    .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .RD_DATA_A(rd_a),
    .RD_DATA_B(rd_b), .WIDE_DATA_PAIR(wide_d), .WIDE_ADDRESS_PAIR(wide_a), .STACK_POINTER(sp),
    .VECTOR_TABLE_BASE(vtb), .INSTRUCTION_POINTER(iptr), .STATUS_FLAGS(status_flags),
    .IRQ_ACCEPT_OK(acc_ok));
  cpu_core_model i_cpu_core_model (.clk(ref_clk), .dec_wr(dec_wr), .sel_a(sel_a), .sel_b(sel_b),
    .flags_we(flags_we), .flags(alu_flags), .ip_load(ip_load), .ip_next(ip_next), .evt(irq_evt));

  // ----
  // helpers
  // ----
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic swr(input sel_t a, input addr20_t d);
    @(posedge ref_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    sw_wdata <= ~d;
  endtask
  task automatic srd(input sel_t a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    chk(what, exp, {12'h0, sw_rdata});
  endtask
  task automatic cf(input logic [10:0] exp);
    #1;
    chk("flags", {21'h0, exp}, {21'h0, status_flags});
  endtask
  function automatic addr20_t pat(input int s);
    return 20'hf5a3c + 20'(s) * 20'h01111;
  endfunction
  function automatic logic [31:0] expv(input int s);
    addr20_t p;
    p = pat(s);
    return (s == 7 || s == 8) ? {12'h0, p} : {16'h0, p[15:0]};
  endfunction

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    for (int s = 0; s < 14; s++)
      srd(5'(s), 32'h0, "reset value");
    for (int s = 0; s < 12; s++)
      swr(5'(s), pat(s));
    for (int s = 0; s < 12; s++)
      srd(5'(s), expv(s), "readback");
    swr(5'h0e, 20'h12345);
    srd(5'h0e, 32'h0, "unmapped");
  endtask
  task automatic t_bytes;
    addr20_t p, q;
    p = pat(1);
    q = pat(2);
    swr(5'h10, 20'h00034);
    swr(5'h11, 20'h00012);
    swr(5'h13, 20'h000a7);
    srd(5'h00, 32'h1234, "data0 bytes");
    srd(5'h01, {16'h0, 8'ha7, p[7:0]}, "data1 upper byte");
    srd(5'h11, 32'h12, "data0 upper alone");
    idle(2);
    chk("wide data", {q[15:0], 16'h1234}, wide_d);
    p = pat(4);
    q = pat(5);
    chk("wide address", {q[15:0], p[15:0]}, wide_a);
  endtask
  task automatic t_bank_stack;
    addr20_t p, q;
    p = pat(10);
    q = pat(9);
    swr(5'h0c, 20'h00010);
    cf(11'h010);
    srd(5'h00, 32'h0, "bank one data0");
    swr(5'h00, 20'h05555);
    srd(5'h00, 32'h5555, "bank one write");
    swr(5'h0c, 20'h00000);
    srd(5'h00, 32'h1234, "bank zero kept");
    srd(5'h0d, {16'h0, p[15:0]}, "current sp isp");
    idle(2);
    chk("sp out", {16'h0, p[15:0]}, {16'h0, sp});
    swr(5'h0c, 20'h00080);
    srd(5'h0d, {16'h0, q[15:0]}, "current sp usp");
    swr(5'h0d, 20'h0beef);
    srd(5'h09, 32'hbeef, "usp via alias");
    srd(5'h0a, {16'h0, p[15:0]}, "isp untouched");
  endtask
  task automatic t_flags;
    swr(5'h0c, 20'h007ff);
    cf(11'h7fd);
    i_cpu_core_model.alu('{1'b1, 1'b1, 1'b0, 1'b1});
    cf(11'h7f5);
    i_cpu_core_model.alu('{1'b0, 1'b0, 1'b1, 1'b0});
    cf(11'h7d8);
  endtask
  task automatic t_acc(input logic [10:0] f, input logic [2:0] l, input logic m, input logic e);
    swr(5'h0c, {9'h0, f});
    @(posedge ref_clk);
    irq_req <= 1'b1;
    irq_lvl <= l;
    irq_msk <= m;
    idle(2);
    chk("accept ok", {31'h0, e}, {31'h0, acc_ok});
  endtask
  task automatic t_irq;
    t_acc(11'h3c0, 3'h4, 1'b1, 1'b1);
    t_acc(11'h3c0, 3'h3, 1'b1, 1'b0);
    t_acc(11'h380, 3'h4, 1'b1, 1'b0);
    t_acc(11'h380, 3'h4, 1'b0, 1'b1);
    t_acc(11'h7c0, 3'h7, 1'b0, 1'b0);
    irq_req <= 1'b0;
    swr(5'h0c, 20'h000c0);
    i_cpu_core_model.irq('{1'b1, 1'b0, 6'h00, 3'h5});
    cf(11'h500);
    swr(5'h0c, 20'h000c0);
    i_cpu_core_model.irq('{1'b0, 1'b1, 6'h20, 3'h0});
    cf(11'h080);
    i_cpu_core_model.irq('{1'b0, 1'b1, 6'h1f, 3'h0});
    cf(11'h000);
  endtask
  task automatic t_dec;
    i_cpu_core_model.wr(5'h08, 20'habcde);
    i_cpu_core_model.wr(5'h07, 20'h12345);
    i_cpu_core_model.pick(5'h08, 5'h07);
    idle(2);
    chk("operand a", 32'habcde, {12'h0, rd_a});
    chk("operand b", 32'h12345, {12'h0, rd_b});
    chk("table base", 32'h12345, {12'h0, vtb});
    i_cpu_core_model.jump(20'h54321);
    idle(2);
    chk("ip", 32'h54321, {12'h0, iptr});
  endtask

  // ----
  // run
  // ----
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    conclude;
  end
  initial
  begin
    error_cnt = 0;
    checks_done = 0;
    reset = 1'b1;
    {irq_req, irq_lvl, irq_msk, sw_wr, sw_rd} = '0;
    sw_addr = '0;
    sw_wdata = '0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_bytes;
    t_bank_stack;
    t_flags;
    t_irq;
    t_dec;
    conclude;
  end
endmodule // testbench

`default_nettype wire
